// ===== design/dms_switch_map.svh
// offsets, field positions, reset values and timing counts of the switch
`ifndef DMS_SWITCH_MAP_SVH
`define DMS_SWITCH_MAP_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define DMS_ADDR_W 8
`define DMS_OFF_CTRL 8'h00
`define DMS_OFF_OP_THR 8'h04
`define DMS_OFF_REL_THR 8'h08
`define DMS_OFF_STATUS 8'h0C
`define DMS_OFF_INT_STAT 8'h10
`define DMS_OFF_INT_MASK 8'h14

// ****************************************************************
// field positions
// ****************************************************************
`define DMS_CTRL_UNIPOLAR 0
`define DMS_CTRL_OPEN_DRAIN 1
`define DMS_CTRL_SLOW_RATE 2
`define DMS_ST_NORTH 0
`define DMS_ST_SOUTH 1
`define DMS_ST_FIRST_DONE 2
`define DMS_ST_AWAKE 3
`define DMS_INT_NORTH_CHG 0
`define DMS_INT_SOUTH_CHG 1
`define DMS_INT_FIRST 2

// ****************************************************************
// reset values
// ****************************************************************
`define DMS_CTRL_RST 3'h0
`define DMS_OP_THR_RST 16'h0BB8
`define DMS_REL_THR_RST 16'h05DC
`define DMS_INT_MASK_RST 3'h0

// ****************************************************************
// timing
// ****************************************************************
`define DMS_CLK_PERIOD_NS 25
`define DMS_T_ON_NS 55000
`define DMS_T_ACTIVE_NS 40000
`define DMS_T_S_FAST_MS 50
`define DMS_T_S_SLOW_MS 200
`define DMS_ACTIVE_CYC (`DMS_T_ACTIVE_NS / `DMS_CLK_PERIOD_NS)
`define DMS_T_ON_CYC (`DMS_T_ON_NS / `DMS_CLK_PERIOD_NS)
`define DMS_T_S_FAST_CYC (`DMS_T_S_FAST_MS * 1000000 / `DMS_CLK_PERIOD_NS)
`define DMS_T_S_SLOW_CYC (`DMS_T_S_SLOW_MS * 1000000 / `DMS_CLK_PERIOD_NS)

`endif

// ===== design/dms_pkg.sv
// types shared by the duty-cycled magnetic switch
package dms_pkg;

  typedef logic signed [15:0] dms_flux_t;
  typedef logic [15:0] dms_mag_t;

  typedef enum logic [2:0] {
    DMS_ST_WAKE = 3'b001,
    DMS_ST_SAMPLE = 3'b010,
    DMS_ST_SLEEP = 3'b100
  } dms_state_t;

endpackage

// ===== design/dms_switch.sv
// duty-cycled magnetic switch: sampling sequencer, outputs and registers
`timescale 1ns/1ps
`include "dms_switch_map.svh"

// ****************************************************************
// hysteresis comparator for one output channel
// ****************************************************************
module dms_hyst (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sample_en,
  input wire dms_pkg::dms_mag_t mag,
  input wire dms_pkg::dms_mag_t operate_threshold,
  input wire dms_pkg::dms_mag_t release_threshold,
  output logic active_q
);
  import dms_pkg::*;

  // between the two thresholds the previous state is kept
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      active_q <= 1'b0;
    end else if (sample_en) begin
      if (mag >= operate_threshold) begin
        active_q <= 1'b1;
      end else if (mag < release_threshold) begin
        active_q <= 1'b0;
      end
    end
  end
endmodule

module dms_switch #(
  parameter int SAMPLE_FAST_CYC = `DMS_T_S_FAST_CYC,
  parameter int SAMPLE_SLOW_CYC = `DMS_T_S_SLOW_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire dms_pkg::dms_flux_t field_in,
  input wire logic [`DMS_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic north_output_o,
  output logic north_output_oe,
  output logic south_output_o,
  output logic south_output_oe,
  output logic awake,
  output logic irq
);
  import dms_pkg::*;

  localparam int ACTIVE_CYC = `DMS_ACTIVE_CYC;
  localparam int T_ON_CYC = `DMS_T_ON_CYC;

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  // the sleep part of a period must be positive and the whole
  // power-on sequence must fit in the power-on time
  if (SAMPLE_FAST_CYC <= ACTIVE_CYC + 1 || SAMPLE_SLOW_CYC <= ACTIVE_CYC + 1)
  begin : g_bad_period
    $error("sample period shorter than the active window");
  end
  if (ACTIVE_CYC + 2 > T_ON_CYC) begin : g_bad_ton
    $error("active window does not fit in the power-on time");
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [2:0] ctrl_q;
  dms_mag_t op_thr_q;
  dms_mag_t rel_thr_q;
  logic [2:0] int_stat_q;
  logic [2:0] int_stat_d;
  logic [2:0] int_mask_q;
  logic [2:0] int_set;
  logic [31:0] rdata_d;
  logic wr_ctrl;
  logic wr_int;

  logic unipolar;
  logic open_drain;
  assign unipolar = ctrl_q[`DMS_CTRL_UNIPOLAR];
  assign open_drain = ctrl_q[`DMS_CTRL_OPEN_DRAIN];

  assign wr_ctrl = reg_wr && (reg_addr == `DMS_OFF_CTRL);
  assign wr_int = reg_wr && (reg_addr == `DMS_OFF_INT_STAT);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `DMS_CTRL_RST;
      op_thr_q <= `DMS_OP_THR_RST;
      rel_thr_q <= `DMS_REL_THR_RST;
      int_mask_q <= `DMS_INT_MASK_RST;
    end else if (reg_wr) begin
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata[2:0];
      end
      if (reg_addr == `DMS_OFF_OP_THR) begin
        op_thr_q <= reg_wdata[15:0];
      end
      if (reg_addr == `DMS_OFF_REL_THR) begin
        rel_thr_q <= reg_wdata[15:0];
      end
      if (reg_addr == `DMS_OFF_INT_MASK) begin
        int_mask_q <= reg_wdata[2:0];
      end
    end
  end

  // ****************************************************************
  // sampling sequencer
  // ****************************************************************
  dms_state_t state_q;
  logic [31:0] cnt_q;
  logic [31:0] sleep_len;
  logic first_done_q;
  logic sample_en;

  // the period runs from one sample to the next, so sleep takes
  // what is left after the active window
  assign sleep_len = ctrl_q[`DMS_CTRL_SLOW_RATE] ?
    32'(SAMPLE_SLOW_CYC - ACTIVE_CYC - 1) :
    32'(SAMPLE_FAST_CYC - ACTIVE_CYC - 1);
  assign sample_en = (state_q == DMS_ST_SAMPLE);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= DMS_ST_WAKE;
      cnt_q <= 32'h0000_0000;
    end else begin
      unique case (state_q)
        DMS_ST_WAKE: begin
          if (cnt_q == 32'(ACTIVE_CYC - 1)) begin
            state_q <= DMS_ST_SAMPLE;
            cnt_q <= 32'h0000_0000;
          end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
          end
        end
        DMS_ST_SAMPLE: begin
          state_q <= DMS_ST_SLEEP;
          cnt_q <= 32'h0000_0000;
        end
        DMS_ST_SLEEP: begin
          if (cnt_q >= sleep_len - 32'h0000_0001) begin
            state_q <= DMS_ST_WAKE;
            cnt_q <= 32'h0000_0000;
          end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
          end
        end
        default: begin
          state_q <= DMS_ST_WAKE;
          cnt_q <= 32'h0000_0000;
        end
      endcase
    end
  end

  assign awake = (state_q != DMS_ST_SLEEP);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      first_done_q <= 1'b0;
    end else if (sample_en) begin
      first_done_q <= 1'b1;
    end
  end

  // ****************************************************************
  // field magnitude per channel
  // ****************************************************************
  // positive flux is bottom-to-top, a south pole at the top face
  logic [16:0] neg_flux;
  dms_mag_t pos_mag;
  dms_mag_t neg_mag;
  dms_mag_t abs_mag;
  dms_mag_t north_mag;
  dms_mag_t south_mag;

  assign neg_flux = 17'h0_0000 - {field_in[15], field_in};
  // the 17-bit negation gives the most negative code its full magnitude, 16'h8000
  assign neg_mag = field_in[15] ?
    (neg_flux[16] ? 16'hFFFF : neg_flux[15:0]) : 16'h0000;
  assign pos_mag = field_in[15] ? 16'h0000 : field_in;
  assign abs_mag = field_in[15] ? neg_mag : pos_mag;
  assign north_mag = unipolar ? neg_mag : abs_mag;
  assign south_mag = unipolar ? pos_mag : 16'h0000;

  logic north_act;
  logic south_act;

  dms_hyst u_north (
    .clock(clock),
    .rst_n(rst_n),
    .sample_en(sample_en),
    .mag(north_mag),
    .operate_threshold(op_thr_q),
    .release_threshold(rel_thr_q),
    .active_q(north_act)
  );

  dms_hyst u_south (
    .clock(clock),
    .rst_n(rst_n),
    .sample_en(sample_en),
    .mag(south_mag),
    .operate_threshold(op_thr_q),
    .release_threshold(rel_thr_q),
    .active_q(south_act)
  );

  // ****************************************************************
  // output drivers
  // ****************************************************************
  // active means low; zero field leaves both pins high or released
  logic north_on;
  logic south_on;
  assign north_on = first_done_q && north_act;
  assign south_on = first_done_q && south_act && unipolar;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      north_output_o <= 1'b1;
      north_output_oe <= 1'b1;
      south_output_o <= 1'b1;
      south_output_oe <= 1'b1;
    end else begin
      // open-drain never drives high, so a shared node reads as a
      // wired AND of every sensor on it
      north_output_o <= open_drain ? 1'b0 : ~north_on;
      north_output_oe <= open_drain ? north_on : 1'b1;
      south_output_o <= open_drain ? 1'b0 : ~south_on;
      south_output_oe <= open_drain ? south_on : 1'b1;
    end
  end

  // ****************************************************************
  // interrupts
  // ****************************************************************
  logic north_on_q;
  logic south_on_q;
  logic first_done_prev_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      north_on_q <= 1'b0;
      south_on_q <= 1'b0;
      first_done_prev_q <= 1'b0;
    end else begin
      north_on_q <= north_on;
      south_on_q <= south_on;
      first_done_prev_q <= first_done_q;
    end
  end

  assign int_set[`DMS_INT_NORTH_CHG] = north_on ^ north_on_q;
  assign int_set[`DMS_INT_SOUTH_CHG] = south_on ^ south_on_q;
  assign int_set[`DMS_INT_FIRST] = first_done_q & ~first_done_prev_q;

  // a new event wins over a clear in the same cycle
  assign int_stat_d = (int_stat_q & ~(wr_int ? reg_wdata[2:0] : 3'h0))
    | int_set;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      int_stat_q <= 3'h0;
    end else begin
      int_stat_q <= int_stat_d;
    end
  end

  assign irq = |(int_stat_q & int_mask_q);

  // ****************************************************************
  // read path
  // ****************************************************************
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (reg_addr)
      `DMS_OFF_CTRL: rdata_d[2:0] = ctrl_q;
      `DMS_OFF_OP_THR: rdata_d[15:0] = op_thr_q;
      `DMS_OFF_REL_THR: rdata_d[15:0] = rel_thr_q;
      `DMS_OFF_STATUS: begin
        rdata_d[`DMS_ST_NORTH] = north_on;
        rdata_d[`DMS_ST_SOUTH] = south_on;
        rdata_d[`DMS_ST_FIRST_DONE] = first_done_q;
        rdata_d[`DMS_ST_AWAKE] = awake;
      end
      `DMS_OFF_INT_STAT: rdata_d[2:0] = int_stat_q;
      `DMS_OFF_INT_MASK: rdata_d[2:0] = int_mask_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rdata_d : 32'h0000_0000;
    end
  end

endmodule

// ===== test/dms_switch_assertions.sv
// concurrent checks on the pins and sequencer of the magnetic switch
`timescale 1ns/1ps
module dms_switch_assertions #(
  parameter int SAMPLE_FAST_CYC = 2000,
  parameter int SAMPLE_SLOW_CYC = 4000
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic north_output_o,
  input wire logic north_output_oe,
  input wire logic south_output_o,
  input wire logic south_output_oe,
  input wire logic awake
);
  // ****************************************************************
  // helper counters
  // ****************************************************************
  localparam int ACTIVE_CYC = 1600;
  localparam int T_ON_CYC = 2200;
  logic north_lvl;
  logic south_lvl;
  logic awake_q;
  logic seen_q;
  int act_q;
  int per_q;
  int on_q;
  // level a pulled-up wire shows, so drive type does not matter
  assign north_lvl = !(north_output_oe && !north_output_o);
  assign south_lvl = !(south_output_oe && !south_output_o);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      awake_q <= 1'b1;
      seen_q <= 1'b0;
      act_q <= 0;
      per_q <= 0;
      on_q <= 0;
    end else begin
      awake_q <= awake;
      act_q <= awake ? act_q + 1 : 0;
      per_q <= (awake_q && !awake) ? 1 : per_q + 1;
      if (awake_q && !awake) begin
        seen_q <= 1'b1;
      end
      if (!seen_q) begin
        on_q <= on_q + 1;
      end
    end
  end
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  sequence s_wake_end;
    awake ##1 !awake;
  endsequence
  property p_active;
    s_wake_end |-> act_q == ACTIVE_CYC + 1;
  endproperty
  property p_period;
    s_wake_end |-> !seen_q || per_q == SAMPLE_FAST_CYC
      || per_q == SAMPLE_SLOW_CYC;
  endproperty
  property p_on_time;
    !seen_q |-> on_q < T_ON_CYC - 1;
  endproperty
  property p_released;
    !seen_q |-> north_lvl && south_lvl;
  endproperty
  property p_north_hold;
    $changed(north_lvl) |-> $past(awake, 2) && !$past(awake);
  endproperty
  property p_south_hold;
    $changed(south_lvl) |-> $past(awake, 2) && !$past(awake);
  endproperty
  property p_od_low;
    (north_output_oe || !north_output_o)
      && (south_output_oe || !south_output_o);
  endproperty
  property p_one_pole;
    north_lvl || south_lvl;
  endproperty
  a_active: assert property (p_active)
    else $error("wake window length off");
  a_period: assert property (p_period)
    else $error("sample period off");
  a_on_time: assert property (p_on_time)
    else $error("first sample late");
  a_released: assert property (p_released)
    else $error("pin active before first sample");
  a_north_hold: assert property (p_north_hold)
    else $error("north pin moved outside a sample");
  a_south_hold: assert property (p_south_hold)
    else $error("south pin moved outside a sample");
  a_od_low: assert property (p_od_low)
    else $error("released pin shows high data");
  a_one_pole: assert property (p_one_pole)
    else $error("both pins active");
endmodule

// ===== test/dms_host.sv
// host input pins with pull-ups that read the switch outputs
`timescale 1ns/1ps
module dms_host (
  input wire logic north_output_o,
  input wire logic north_output_oe,
  input wire logic south_output_o,
  input wire logic south_output_oe,
  output logic north_level,
  output logic south_level,
  output logic shared_level
);
  // a released pin floats up through the pull-up resistor
  assign north_level = north_output_oe ? north_output_o : 1'b1;
  assign south_level = south_output_oe ? south_output_o : 1'b1;
  // one shared node: any active sensor pulls it low
  assign shared_level = north_level & south_level;
endmodule

// ===== test/test_dms_switch.sv
// self-checking bench for the duty-cycled magnetic switch
`timescale 1ns/1ps
`include "dms_switch_map.svh"
module test_dms_switch;
  import dms_pkg::*;
  // ****************************************************************
  // signals and tasks
  // ****************************************************************
  localparam int FAST = 2000;
  localparam int SLOW = 4000;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  dms_flux_t field_in = 16'h0000;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic north_output_o, north_output_oe, south_output_o, south_output_oe;
  logic awake, irq, north_level, south_level, shared_level;
  int miscompares = 0;
  int compares = 0;
  int n;
  always #12.5 clock = ~clock;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  // counts edges up to the end of the next wake window
  task automatic fall(output int c);
    c = 0;
    while (awake !== 1'b1 && c < 9000) begin
      @(posedge clock);
      #1;
      c++;
    end
    while (awake !== 1'b0 && c < 9000) begin
      @(posedge clock);
      #1;
      c++;
    end
  endtask
  task automatic smp(input logic [15:0] f);
    @(posedge clock);
    field_in <= f;
    #1;
    fall(n);
    @(posedge clock);
    #1;
  endtask
  task automatic pins(input logic [2:0] exp);
    chk({29'h0, north_level, south_level, shared_level}, {29'h0, exp});
  endtask
  task automatic results;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  dms_switch #(.SAMPLE_FAST_CYC(FAST), .SAMPLE_SLOW_CYC(SLOW)) dms_switch_i (
    .clock(clock), .rst_n(rst_n), .field_in(field_in),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .north_output_o(north_output_o), .north_output_oe(north_output_oe),
    .south_output_o(south_output_o), .south_output_oe(south_output_oe),
    .awake(awake), .irq(irq));
  dms_host dms_host_i (
    .north_output_o(north_output_o), .north_output_oe(north_output_oe),
    .south_output_o(south_output_o), .south_output_oe(south_output_oe),
    .north_level(north_level), .south_level(south_level),
    .shared_level(shared_level));
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    #1;
    pins(3'b111);
    rd(`DMS_OFF_CTRL, 32'h0);
    rd(`DMS_OFF_OP_THR, 32'h0BB8);
    rd(`DMS_OFF_REL_THR, 32'h05DC);
    rd(`DMS_OFF_INT_MASK, 32'h0);
    rd(8'h18, 32'h0);
    rd(`DMS_OFF_STATUS, 32'h8);
    @(posedge clock);
    #1;
    chk(reg_rdata, 32'h0);
    smp(16'hF060);
    pins(3'b010);
    chk(irq, 1'b0);
    wr(`DMS_OFF_INT_MASK, 32'h7);
    rd(`DMS_OFF_INT_STAT, 32'h5);
    chk(irq, 1'b1);
    rd(`DMS_OFF_STATUS, 32'h5);
    wr(`DMS_OFF_INT_STAT, 32'h5);
    smp(16'h0FA0);
    pins(3'b010);
    rd(`DMS_OFF_INT_STAT, 32'h0);
    chk(irq, 1'b0);
    smp(16'h07D0);
    pins(3'b010);
    smp(16'h03E8);
    pins(3'b111);
    rd(`DMS_OFF_INT_STAT, 32'h1);
    wr(`DMS_OFF_INT_STAT, 32'h1);
    smp(16'h0BB8);
    pins(3'b010);
    wr(`DMS_OFF_CTRL, 32'h1);
    smp(16'h0FA0);
    pins(3'b100);
    smp(16'hF060);
    pins(3'b010);
    smp(16'h0000);
    pins(3'b111);
    wr(`DMS_OFF_CTRL, 32'h3);
    smp(16'hF060);
    chk({north_output_o, north_output_oe, south_output_oe}, 3'b010);
    pins(3'b010);
    fall(n);
    fall(n);
    chk(n, FAST);
    wr(`DMS_OFF_CTRL, 32'h7);
    fall(n);
    fall(n);
    chk(n, SLOW);
    wr(`DMS_OFF_OP_THR, 32'h1388);
    wr(`DMS_OFF_REL_THR, 32'h1000);
    rd(`DMS_OFF_OP_THR, 32'h1388);
    rd(`DMS_OFF_REL_THR, 32'h1000);
    smp(16'hF060);
    pins(3'b111);
    results;
  end
  initial begin
    repeat (50000) @(posedge clock);
    miscompares++;
    results;
  end
endmodule
bind dms_switch dms_switch_assertions #(
  .SAMPLE_FAST_CYC(SAMPLE_FAST_CYC), .SAMPLE_SLOW_CYC(SAMPLE_SLOW_CYC)
) dms_switch_assertions_i (
  .clock(clock), .rst_n(rst_n),
  .north_output_o(north_output_o), .north_output_oe(north_output_oe),
  .south_output_o(south_output_o), .south_output_oe(south_output_oe),
  .awake(awake));
